/* bfsr_regs.svh */
// Address codes, field positions, reset values and counts of the status bank
// Overview of operation
// - Overcurrent 9-12: bridge 12 high at bit 7, bridge 9 low at bit 0.
// - Overcurrent on a high-side switch of 9-12 latches and disables it.
// - Overcurrent on a low-side switch of 9-12 latches and disables it.
// - Every status bit reads zero, no fault, after reset.
// - Open load 1-4: bridge 4 high at bit 7, bridge 1 low at bit 0.
// - Open load 5-8: bridge 8 high at bit 7, bridge 5 low at bit 0.
// - High-side open load latches its bit, never disabling the switch.
// - Low-side open load latches its bit until a read clears it.
// - Codes: 11110 OC 9-12, 00001 open load 1-4, 10001 open load 5-8.
// - Bits of absent outputs are reserved and always read zero.
// - Global load error is the OR of all bits; it falls once all clear.
`ifndef BFSR_REGS_SVH
`define BFSR_REGS_SVH

// Register access port
`define BFSR_ADDR_W        5
`define BFSR_DATA_W        8
`define BFSR_ADDR_OC_9_12  5'h1e
`define BFSR_ADDR_OL_1_4   5'h01
`define BFSR_ADDR_OL_5_8   5'h11
`define BFSR_UNMAPPED_DATA 8'h00

// Reset values
`define BFSR_STATUS_RESET  8'h00
`define BFSR_FAULT_RESET   24'h00_0000
`define BFSR_EN_RESET      4'h0

// Bit of a pair: high side above low side
`define BFSR_HIGH_POS      1
`define BFSR_LOW_POS       0

// Layout of the packed fault input vector
`define BFSR_FAULT_W       24
`define BFSR_OC_HIGH_LSB   0
`define BFSR_OC_LOW_LSB    4
`define BFSR_OL_HIGH_LSB   8
`define BFSR_OL_LOW_LSB    16
`define BFSR_OC_FIRST      8
`define BFSR_PER_BYTE      4

// Pin input synchroniser depth
`define BFSR_SYNC_STAGES   3

`endif

/* bfsr_pkg.sv */
// Types shared by the fault status bank
`default_nettype none
package bfsr_pkg;

  // Register selected by a read address code
  typedef enum logic [1:0] {
    sel_none,
    sel_oc_9_12,
    sel_ol_1_4,
    sel_ol_5_8
  } bfsr_sel_t;

  typedef logic [7:0] bfsr_byte_t;

endpackage : bfsr_pkg
`default_nettype wire

/* bfsr_status_byte.sv */
// One read-to-clear status byte with set-over-clear priority
`timescale 1ns/1ns
`default_nettype none
`include "bfsr_regs.svh"
module bfsr_status_byte #(
  parameter logic [7:0] KEEP_MASK = 8'hff
) (
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Fault events and read clear
  input  wire logic [7:0] set_in,
  input  wire logic       clear_in,
  // Latched bits
  output logic      [7:0] status_out
);

  logic [7:0] next_status;

  // Clear on read, but a fault in the same cycle keeps its bit
  always_comb begin
    next_status = status_out;
    if (ce_in) begin
      next_status = ((status_out & ~{8{clear_in}}) | set_in)
                    & KEEP_MASK;
    end
  end

  // Status register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      status_out <= `BFSR_STATUS_RESET;
    end else begin
      status_out <= next_status;
    end
  end

  // A fault that meets the clearing read survives it
  set_wins_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in && clear_in && (|(set_in & KEEP_MASK))
    |=> (status_out & $past(set_in & KEEP_MASK)) ==
        $past(set_in & KEEP_MASK))
    else $error("fault lost against read clear");

  // Reserved bits never rise
  reserved_zero_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    (status_out & ~KEEP_MASK) == 8'h00)
    else $error("reserved status bit set");

endmodule : bfsr_status_byte
`default_nettype wire

/* bfsr_fault_status.sv */
// Fault status bank: overcurrent 9-12 and open load 1-8, read-to-clear
`timescale 1ns/1ns
`default_nettype none
`include "bfsr_regs.svh"
module bfsr_fault_status #(
  parameter logic [11:0] PRESENT_MASK = 12'hfff
) (
  // Clock, reset, enable
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       ce_in,
  // Register read port
  input  wire logic       rd_en_in,
  input  wire logic [4:0] rd_addr_in,
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  output logic            rd_hit_out,
  // Overcurrent detectors, bridges 9-12 (bit 0 is bridge 9)
  input  wire logic [3:0] oc_high_in,
  input  wire logic [3:0] oc_low_in,
  // Open-load detectors, bridges 1-8 (bit 0 is bridge 1)
  input  wire logic [7:0] ol_high_in,
  input  wire logic [7:0] ol_low_in,
  // Switch on requests and gated enables, bridges 9-12
  input  wire logic [3:0] high_on_req_in,
  input  wire logic [3:0] low_on_req_in,
  output logic      [3:0] high_enable_out,
  output logic      [3:0] low_enable_out,
  // Global load error flag
  output logic            global_load_error_out
);

  // Address code decode, used by read data and read clear
  function automatic bfsr_pkg::bfsr_sel_t bfsr_decode(
    input logic [4:0] addr
  );
    bfsr_pkg::bfsr_sel_t sel;
    sel = bfsr_pkg::sel_none;
    case (addr)
      `BFSR_ADDR_OC_9_12: sel = bfsr_pkg::sel_oc_9_12;
      `BFSR_ADDR_OL_1_4:  sel = bfsr_pkg::sel_ol_1_4;
      `BFSR_ADDR_OL_5_8:  sel = bfsr_pkg::sel_ol_5_8;
      default:            sel = bfsr_pkg::sel_none;
    endcase
    return sel;
  endfunction : bfsr_decode

  // Raw detector pins packed into one vector
  logic [23:0] fault_raw;
  logic [23:0] sync_a;
  logic [23:0] sync_b;
  logic [23:0] sync_c;
  logic [23:0] fault_filt;
  logic [23:0] next_sync_a;
  logic [23:0] next_sync_b;
  logic [23:0] next_sync_c;
  logic [23:0] next_fault_filt;

  // Events per status byte and byte masks
  bfsr_pkg::bfsr_byte_t oc_set;
  bfsr_pkg::bfsr_byte_t ol14_set;
  bfsr_pkg::bfsr_byte_t ol58_set;
  bfsr_pkg::bfsr_byte_t oc_byte;
  bfsr_pkg::bfsr_byte_t ol14_byte;
  bfsr_pkg::bfsr_byte_t ol58_byte;
  logic [3:0]           oc_high_trip;
  logic [3:0]           oc_low_trip;
  logic [3:0]           oc_present;

  // Read strobes
  bfsr_pkg::bfsr_sel_t  rd_sel;
  logic                 clr_oc;
  logic                 clr_ol14;
  logic                 clr_ol58;

  // Next values of the output registers
  logic [7:0]           next_rd_data;
  logic                 next_rd_valid;
  logic                 next_rd_hit;
  logic [3:0]           next_high_en;
  logic [3:0]           next_low_en;
  logic                 next_global;

  localparam logic [7:0] OC_MASK = {
    {2{PRESENT_MASK[11]}}, {2{PRESENT_MASK[10]}},
    {2{PRESENT_MASK[9]}},  {2{PRESENT_MASK[8]}}
  };
  localparam logic [7:0] OL14_MASK = {
    {2{PRESENT_MASK[3]}}, {2{PRESENT_MASK[2]}},
    {2{PRESENT_MASK[1]}}, {2{PRESENT_MASK[0]}}
  };
  localparam logic [7:0] OL58_MASK = {
    {2{PRESENT_MASK[7]}}, {2{PRESENT_MASK[6]}},
    {2{PRESENT_MASK[5]}}, {2{PRESENT_MASK[4]}}
  };

  assign fault_raw  = {ol_low_in, ol_high_in, oc_low_in, oc_high_in};
  assign oc_present = PRESENT_MASK[11:8];

  // Three-stage pin sync; a level counts once stages two and three agree
  always_comb begin
    next_sync_a     = sync_a;
    next_sync_b     = sync_b;
    next_sync_c     = sync_c;
    next_fault_filt = fault_filt;
    if (ce_in) begin
      next_sync_a     = fault_raw;
      next_sync_b     = sync_a;
      next_sync_c     = sync_b;
      next_fault_filt = ((sync_b ~^ sync_c) & sync_c) |
                        ((sync_b ^ sync_c) & fault_filt);
    end
  end

  // Synchroniser and filter registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_a     <= `BFSR_FAULT_RESET;
      sync_b     <= `BFSR_FAULT_RESET;
      sync_c     <= `BFSR_FAULT_RESET;
      fault_filt <= `BFSR_FAULT_RESET;
    end else begin
      sync_a     <= next_sync_a;
      sync_b     <= next_sync_b;
      sync_c     <= next_sync_c;
      fault_filt <= next_fault_filt;
    end
  end

  // Map each bridge's filtered faults onto its high/low bit pair
  for (genvar g = 0; g < `BFSR_PER_BYTE; g++) begin : g_pair
    assign oc_set[2*g+`BFSR_HIGH_POS] =
      fault_filt[`BFSR_OC_HIGH_LSB+g];
    assign oc_set[2*g+`BFSR_LOW_POS] =
      fault_filt[`BFSR_OC_LOW_LSB+g];
    assign ol14_set[2*g+`BFSR_HIGH_POS] =
      fault_filt[`BFSR_OL_HIGH_LSB+g];
    assign ol14_set[2*g+`BFSR_LOW_POS] =
      fault_filt[`BFSR_OL_LOW_LSB+g];
    assign ol58_set[2*g+`BFSR_HIGH_POS] =
      fault_filt[`BFSR_OL_HIGH_LSB+`BFSR_PER_BYTE+g];
    assign ol58_set[2*g+`BFSR_LOW_POS] =
      fault_filt[`BFSR_OL_LOW_LSB+`BFSR_PER_BYTE+g];
    // A switch trips on the latched bit or on a fault arriving now
    assign oc_high_trip[g] = oc_byte[2*g+`BFSR_HIGH_POS] |
                             oc_set[2*g+`BFSR_HIGH_POS];
    assign oc_low_trip[g]  = oc_byte[2*g+`BFSR_LOW_POS] |
                             oc_set[2*g+`BFSR_LOW_POS];
  end

  // Read address decode and clear strobes
  assign rd_sel   = bfsr_decode(rd_addr_in);
  assign clr_oc   = rd_en_in && (rd_sel == bfsr_pkg::sel_oc_9_12);
  assign clr_ol14 = rd_en_in && (rd_sel == bfsr_pkg::sel_ol_1_4);
  assign clr_ol58 = rd_en_in && (rd_sel == bfsr_pkg::sel_ol_5_8);

  // Overcurrent status, bridges 9-12
  bfsr_status_byte #(
    .KEEP_MASK (OC_MASK)
  ) u_oc_9_12 (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (oc_set),
    .clear_in   (clr_oc),
    .status_out (oc_byte)
  );

  // Open-load status, bridges 1-4
  bfsr_status_byte #(
    .KEEP_MASK (OL14_MASK)
  ) u_ol_1_4 (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (ol14_set),
    .clear_in   (clr_ol14),
    .status_out (ol14_byte)
  );

  // Open-load status, bridges 5-8
  bfsr_status_byte #(
    .KEEP_MASK (OL58_MASK)
  ) u_ol_5_8 (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .ce_in      (ce_in),
    .set_in     (ol58_set),
    .clear_in   (clr_ol58),
    .status_out (ol58_byte)
  );

  // Read data, switch enables and global flag
  always_comb begin
    next_rd_data  = rd_data_out;
    next_rd_valid = 1'b0;
    next_rd_hit   = rd_hit_out;
    next_high_en  = high_enable_out;
    next_low_en   = low_enable_out;
    next_global   = global_load_error_out;
    if (!ce_in) begin
      next_rd_valid = rd_valid_out;
    end else begin
      if (rd_en_in) begin
        next_rd_valid = 1'b1;
        next_rd_hit   = (rd_sel != bfsr_pkg::sel_none);
        case (rd_sel)
          bfsr_pkg::sel_oc_9_12: next_rd_data = oc_byte;
          bfsr_pkg::sel_ol_1_4:  next_rd_data = ol14_byte;
          bfsr_pkg::sel_ol_5_8:  next_rd_data = ol58_byte;
          default:               next_rd_data = `BFSR_UNMAPPED_DATA;
        endcase
      end
      // Open load never gates an enable; only overcurrent does
      next_high_en = high_on_req_in & ~oc_high_trip & oc_present;
      next_low_en  = low_on_req_in & ~oc_low_trip & oc_present;
      next_global  = (|oc_byte) | (|ol14_byte) | (|ol58_byte);
    end
  end

  // Output registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out           <= `BFSR_STATUS_RESET;
      rd_valid_out          <= 1'b0;
      rd_hit_out            <= 1'b0;
      high_enable_out       <= `BFSR_EN_RESET;
      low_enable_out        <= `BFSR_EN_RESET;
      global_load_error_out <= 1'b0;
    end else begin
      rd_data_out           <= next_rd_data;
      rd_valid_out          <= next_rd_valid;
      rd_hit_out            <= next_rd_hit;
      high_enable_out       <= next_high_en;
      low_enable_out        <= next_low_en;
      global_load_error_out <= next_global;
    end
  end

  // Overcurrent read returns the byte as latched before the clear
  oc_layout_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in && rd_en_in && rd_addr_in == `BFSR_ADDR_OC_9_12
    |=> rd_valid_out && rd_hit_out && rd_data_out == $past(oc_byte))
    else $error("overcurrent read data wrong");

  // Any latched high-side overcurrent keeps its switch off
  high_oc_off_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in |=> (high_enable_out & $past({oc_byte[7], oc_byte[5],
      oc_byte[3], oc_byte[1]})) == 4'h0)
    else $error("high side on during overcurrent");

  // Bridge 9 low overcurrent event latches and turns the switch off
  low_oc_off_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in && fault_filt[`BFSR_OC_LOW_LSB] && PRESENT_MASK[8]
    |=> oc_byte[0] && !low_enable_out[0])
    else $error("bridge 9 low side not tripped");

  // Reset leaves every status byte clear
  reset_clear_a : assert property (@(posedge clk_in)
    rst_in |=> oc_byte == 8'h00 && ol14_byte == 8'h00 && ol58_byte == 8'h00)
    else $error("status not clear after reset");

  // Bridge 3 high open load lands in bit 5, high enable untouched
  ol_high_a : assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && fault_filt[`BFSR_OL_HIGH_LSB+2] && PRESENT_MASK[2]
    |=> ol14_byte[5] && high_enable_out == $past(high_on_req_in &
        ~oc_high_trip & oc_present))
    else $error("open load bit or enable wrong");

  // Bridge 7 low open load lands in bit 4 of the upper byte
  ol_low_a : assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && fault_filt[`BFSR_OL_LOW_LSB+6] && PRESENT_MASK[6]
    |=> ol58_byte[4])
    else $error("bridge 7 low open load not latched");

  // Bridge 8 high open load lands in the top bit
  ol58_top_a : assert property (@(posedge clk_in) disable iff (rst_in)
    ce_in && fault_filt[`BFSR_OL_HIGH_LSB+7] && PRESENT_MASK[7]
    |=> ol58_byte[7])
    else $error("bridge 8 high open load not latched");

  // Unmapped code reads zero and leaves the overcurrent byte uncleared
  unmapped_read_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in && rd_en_in && rd_sel == bfsr_pkg::sel_none
    |=> rd_data_out == 8'h00 && !rd_hit_out &&
        (oc_byte & $past(oc_byte)) == $past(oc_byte))
    else $error("unmapped read misbehaved");

  // Global flag follows the OR of all bytes one cycle later
  global_flag_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in |=> global_load_error_out ==
      $past((|oc_byte) | (|ol14_byte) | (|ol58_byte)))
    else $error("global load error flag wrong");

  // A read with no fault pending empties the byte
  read_clear_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    ce_in && clr_ol14 && ol14_set == 8'h00 |=> ol14_byte == 8'h00)
    else $error("read did not clear open-load byte");

  // Absent outputs never show a bit in the overcurrent or 1-4 bytes
  absent_zero_a : assert property (@(posedge clk_in)
    disable iff (rst_in)
    (oc_byte & ~OC_MASK) == 8'h00 && (ol14_byte & ~OL14_MASK) == 8'h00)
    else $error("absent output bit set");

  // Low clock enable freezes the outputs
  freeze_a : assert property (@(posedge clk_in) disable iff (rst_in)
    !ce_in |=> $stable(rd_data_out) && $stable(high_enable_out) &&
      $stable(global_load_error_out))
    else $error("state moved while clock enable low");

endmodule : bfsr_fault_status
`default_nettype wire

/* bfsr_host_model.sv */
// Host model that issues register reads to the fault status bank
`timescale 1ns/1ns
`default_nettype none
module bfsr_host_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Read orders from the bench
  input  wire logic       go_in,
  input  wire logic [4:0] go_addr_in,
  // Read port toward the bank
  output logic            rd_en_out,
  output logic      [4:0] rd_addr_out
);
  // One read per ordered cycle; the idle address toggles so no stale code
  // is mistaken for a request
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_en_out   <= 1'b0;
      rd_addr_out <= 5'h00;
    end else if (go_in) begin
      rd_en_out   <= 1'b1;
      rd_addr_out <= go_addr_in;
    end else begin
      rd_en_out   <= 1'b0;
      rd_addr_out <= ~rd_addr_out;
    end
  end
endmodule : bfsr_host_model
`default_nettype wire

/* bfsr_tb.sv */
// Self-checking bench for the fault status bank
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [11:0] PM = 12'h7ff; // Bridge 12 absent
  logic       clk_in, rst_in, ce_in, go, rd_en, rd_valid, rd_hit, gle;
  logic [4:0] ga, rd_addr;
  logic [7:0] rd_data, olh, oll;
  logic [3:0] och, ocl, hreq, lreq, hen, len;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  int         err_count, compares;

  // Host on the read port and the bank under test
  bfsr_host_model u_bfsr_host_model (.clk_in(clk_in), .rst_in(rst_in),
    .go_in(go), .go_addr_in(ga), .rd_en_out(rd_en), .rd_addr_out(rd_addr));
  bfsr_fault_status #(.PRESENT_MASK(PM)) u_bfsr_fault_status (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .rd_en_in(rd_en), .rd_addr_in(rd_addr), .rd_data_out(rd_data),
    .rd_valid_out(rd_valid), .rd_hit_out(rd_hit),
    .oc_high_in(och), .oc_low_in(ocl), .ol_high_in(olh), .ol_low_in(oll),
    .high_on_req_in(hreq), .low_on_req_in(lreq),
    .high_enable_out(hen), .low_enable_out(len),
    .global_load_error_out(gle));

  // Byte bits that belong to present bridges, from bridge index b
  function automatic logic [7:0] keep(input int b);
    for (int i = 0; i < 4; i++) keep[2*i +: 2] = {2{PM[b+i]}};
  endfunction : keep
  // High-side and low-side halves of a status byte
  function automatic logic [3:0] hi(input logic [7:0] v);
    hi = {v[7], v[5], v[3], v[1]};
  endfunction : hi
  function automatic logic [3:0] lo(input logic [7:0] v);
    lo = {v[6], v[4], v[2], v[0]};
  endfunction : lo

  task automatic chk(input string n, input logic [8:0] x,
                     input logic [8:0] g);
    compares++;
    if (g !== x) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask : cyc
  task automatic endt(input string n);
    $display("test %s done", n);
  endtask : endt
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Order one read; the order stays up until idle, so calls run back to back
  task automatic rd(input logic [4:0] a, input logic [7:0] x,
                    input logic h, input logic push);
    @(posedge clk_in);
    go <= 1'b1;
    ga <= a;
    if (push) exp_q.push_back({h, x});
  endtask : rd
  // Drop the order and wait, bounded, for every answer
  task automatic idle;
    int n;
    @(posedge clk_in);
    go <= 1'b0;
    n = 0;
    while (exp_q.size() > 0 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    if (exp_q.size() > 0) begin
      err_count++;
      $display("mismatch read_answer expected done seen timeout");
      conclude();
    end
  endtask : idle

  // Inject faults, check trips and flag, then clear the pins and read back
  task automatic fault(input logic [7:0] oc, input logic [7:0] l14,
                       input logic [7:0] l58, input logic hold);
    logic [7:0] xo, x1, x5;
    xo = oc & keep(8);
    x1 = l14 & keep(0);
    x5 = l58 & keep(4);
    @(posedge clk_in);
    hreq <= 4'($urandom());
    lreq <= 4'($urandom());
    och <= hi(oc);
    ocl <= lo(oc);
    olh <= {hi(l58), hi(l14)};
    oll <= {lo(l58), lo(l14)};
    cyc(8);
    #1;
    chk("high_en", {5'h00, hreq & ~hi(xo) & PM[11:8]},
        {5'h00, hen});
    chk("low_en", {5'h00, lreq & ~lo(xo) & PM[11:8]},
        {5'h00, len});
    chk("load_err", {8'h00, |{xo, x1, x5}}, {8'h00, gle});
    if (hold) begin
      rd(5'h1e, xo, 1'b1, 1'b1);
      rd(5'h1e, xo, 1'b1, 1'b1);
      idle();
    end
    @(posedge clk_in);
    och <= 4'h0;
    ocl <= 4'h0;
    olh <= 8'h00;
    oll <= 8'h00;
    cyc(8);
    rd(5'h1e, xo, 1'b1, 1'b1);
    rd(5'h01, x1, 1'b1, 1'b1);
    rd(5'h11, x5, 1'b1, 1'b1);
    rd(5'h1e, 8'h00, 1'b1, 1'b1);
    rd(5'h01, 8'h00, 1'b1, 1'b1);
    rd(5'h11, 8'h00, 1'b1, 1'b1);
    idle();
    cyc(3);
    #1;
    chk("load_err", 9'h000, {8'h00, gle});
    chk("high_en", {5'h00, hreq & PM[11:8]}, {5'h00, hen});
    chk("low_en", {5'h00, lreq & PM[11:8]}, {5'h00, len});
  endtask : fault

  // Compare each read answer with the oldest expectation
  always @(posedge clk_in) begin
    if (!rst_in && rd_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected_read", 9'h000, 9'h1ff);
      end else begin
        e = exp_q.pop_front();
        chk("read", e, {rd_hit, rd_data});
      end
    end
  end

  // Free-running clock
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    go = 1'b0;
    ga = 5'h00;
    och = 4'h0;
    ocl = 4'h0;
    olh = 8'h00;
    oll = 8'h00;
    hreq = 4'h0;
    lreq = 4'h0;
    err_count = 0;
    compares = 0;
    void'($urandom(32'h72af));
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    // Reset values of every byte, then an unmapped code
    rd(5'h1e, 8'h00, 1'b1, 1'b1);
    rd(5'h01, 8'h00, 1'b1, 1'b1);
    rd(5'h11, 8'h00, 1'b1, 1'b1);
    rd(5'h02, 8'h00, 1'b0, 1'b1);
    idle();
    endt("reset");
    // One fault per byte at a time across every bit of all three bytes
    for (int b = 0; b < 8; b++) begin
      fault(8'h01 << b, 8'h01 << b, 8'h80 >> b, 1'b0);
    end
    endt("walk");
    // Random fault mixes, every second one read while still present
    for (int k = 0; k < 6; k++) begin
      fault(8'($urandom()), 8'($urandom()), 8'($urandom()), k[0]);
    end
    endt("random");
    // No read is taken while the clock enable is low
    @(posedge clk_in);
    ce_in <= 1'b0;
    rd(5'h1e, 8'h00, 1'b1, 1'b0);
    idle();
    cyc(3);
    ce_in <= 1'b1;
    cyc(6);
    endt("enable");
    conclude();
  end
endmodule : tb
`default_nettype wire
